//--- scl_regs.svh
`ifndef SCL_REGS_SVH
`define SCL_REGS_SVH
// register selectors on the decoded telegram command port
`define SCL_SEL_FREEZE 4'h1
`define SCL_SEL_FIELD 4'h2
`define SCL_SEL_OFFSET 4'h3
`define SCL_SEL_FORMAT 4'h4
`define SCL_SEL_GP 4'h5
// field layout and widths
`define SCL_FIELD_W 14
`define SCL_DATA_W 16
`define SCL_FMT_W 3
// output format code for plain analog output
`define SCL_FMT_ANALOG 3'h0
// reset values
`define SCL_FREEZE_RST 1'h0
`define SCL_DATA_RST 16'h0000
`define SCL_FMT_RST 3'h0
`endif

//--- scl_pkg.sv
package scl_pkg;
   // one decoded programming telegram
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] sel;
      logic [15:0] data;
   } scl_cmd_s;
   // lock life cycle
   typedef enum logic [2:0] {
      SCL_OPEN = 3'h1,
      SCL_ARMED = 3'h2,
      SCL_FROZEN = 3'h4
   } scl_lock_e;
endpackage

//--- scl_bitrev.sv
`include "scl_regs.svh"
// mirrors the field word, lsb becomes msb
module scl_bitrev
   import scl_pkg::*;
(
   input wire logic [`SCL_FIELD_W-1:0] val_in,
   output logic [`SCL_FIELD_W-1:0] rev_out
);
   always_comb begin
      for (int i = 0; i < `SCL_FIELD_W; i++) begin
         rev_out[i] = val_in[`SCL_FIELD_W-1-i];
      end
   end
endmodule // scl_bitrev

//--- scl_lock_readout.sv
`include "scl_regs.svh"
module scl_lock_readout
   import scl_pkg::*;
(
   input wire logic clock_in,
   input wire logic rst_n_in, // power-on reset: one power cycle
   input wire scl_cmd_s cmd_in, // decoded supply telegram
   input wire logic [`SCL_FIELD_W-1:0] field_in, // processed field value
   input wire logic nv_freeze_in, // stored lock bit from non-volatile memory
   output logic rd_valid_out, // answer strobe for a read
   output logic [`SCL_DATA_W-1:0] rd_data_out, // answer word
   output logic freeze_store_out, // lock bit to persist
   output logic frozen_out, // settings frozen
   output logic [`SCL_DATA_W-1:0] offset_out, // zero-field offset setting
   output logic [`SCL_FMT_W-1:0] fmt_out, // output format select
   output logic [`SCL_DATA_W-1:0] gp_out // general purpose store
);
   scl_lock_e lock_reg, lock_next; // lock life cycle state
   logic boot_reg, boot_next; // high in first cycle after power-up
   logic store_reg, store_next; // persisted lock bit image
   logic [`SCL_DATA_W-1:0] offset_reg, offset_next;
   logic [`SCL_FMT_W-1:0] fmt_reg, fmt_next;
   logic [`SCL_DATA_W-1:0] gp_reg, gp_next;
   logic vld_reg, vld_next;
   logic [`SCL_DATA_W-1:0] rdd_reg, rdd_next;
   logic [`SCL_FIELD_W-1:0] field_rev; // mirrored field value
   logic accept; // telegrams honoured

   scl_bitrev u_rev (
      .val_in(field_in),
      .rev_out(field_rev)
   );

   // a frozen device listens to nothing on the supply line
   assign accept = (lock_reg != SCL_FROZEN);

   // lock state: the stored bit only bites at the first cycle after power-up,
   // so a freshly written lock leaves programming alive until a power cycle
   always_comb begin
      lock_next = lock_reg;
      boot_next = 1'b0;
      store_next = store_reg | nv_freeze_in; // never cleared except by reset
      unique case (lock_reg)
         SCL_OPEN: begin
            if (boot_reg && nv_freeze_in) begin
               lock_next = SCL_FROZEN;
            end else if (cmd_in.wr && cmd_in.sel == `SCL_SEL_FREEZE && cmd_in.data[0]) begin
               lock_next = SCL_ARMED; // write-one-to-set
               store_next = 1'b1;
            end
         end
         SCL_ARMED: begin
            lock_next = SCL_ARMED; // still programmable until power cycle
         end
         SCL_FROZEN: begin
            lock_next = SCL_FROZEN;
         end
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         lock_reg <= SCL_OPEN;
         boot_reg <= 1'b1;
         store_reg <= `SCL_FREEZE_RST;
      end else begin
         lock_reg <= lock_next;
         boot_reg <= boot_next;
         store_reg <= store_next;
      end
   end

   // setting writes: repeatable while the lock is not effective
   always_comb begin
      offset_next = offset_reg;
      fmt_next = fmt_reg;
      gp_next = gp_reg;
      if (accept && cmd_in.wr) begin
         unique case (cmd_in.sel)
            `SCL_SEL_OFFSET: offset_next = cmd_in.data;
            `SCL_SEL_FORMAT: fmt_next = cmd_in.data[`SCL_FMT_W-1:0];
            `SCL_SEL_GP: gp_next = cmd_in.data;
            default: ; // other selectors are not held here
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         offset_reg <= `SCL_DATA_RST;
         fmt_reg <= `SCL_FMT_RST;
         gp_reg <= `SCL_DATA_RST;
      end else begin
         offset_reg <= offset_next;
         fmt_reg <= fmt_next;
         gp_reg <= gp_next;
      end
   end

   // read answers; unmapped selectors answer zero
   always_comb begin
      vld_next = 1'b0;
      rdd_next = `SCL_DATA_RST;
      if (accept && cmd_in.rd) begin
         vld_next = 1'b1;
         unique case (cmd_in.sel)
            `SCL_SEL_FIELD: begin
               if (fmt_reg == `SCL_FMT_ANALOG) begin
                  rdd_next = {2'h0, field_rev};
               end
            end
            `SCL_SEL_FREEZE: rdd_next = {15'h0000, store_reg};
            `SCL_SEL_OFFSET: rdd_next = offset_reg;
            `SCL_SEL_FORMAT: rdd_next = {13'h0000, fmt_reg};
            `SCL_SEL_GP: rdd_next = gp_reg;
            default: rdd_next = `SCL_DATA_RST;
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         vld_reg <= 1'b0;
         rdd_reg <= `SCL_DATA_RST;
      end else begin
         vld_reg <= vld_next;
         rdd_reg <= rdd_next;
      end
   end

   // outputs come straight from flip-flops
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         frozen_out <= 1'b0;
      end else begin
         frozen_out <= (lock_next == SCL_FROZEN);
      end
   end
   assign rd_valid_out = vld_reg;
   assign rd_data_out = rdd_reg;
   assign freeze_store_out = store_reg;
   assign offset_out = offset_reg;
   assign fmt_out = fmt_reg;
   assign gp_out = gp_reg;

   // checks: all gathered here at the end, after the logic they guard
   // reset aborts every assertion but not the covers, since a reset is one power cycle of the part
   AST_FROZEN_NO_READ: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      lock_reg == SCL_FROZEN && cmd_in.rd |=> !rd_valid_out)
      else $error("read answered while frozen");
   AST_FROZEN_NO_WRITE: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      lock_reg == SCL_FROZEN |=> $stable(offset_out) && $stable(fmt_out))
      else $error("setting changed while frozen");
   AST_STORE_STICKY: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      freeze_store_out |=> freeze_store_out)
      else $error("lock bit cleared");
   AST_ARMED_STILL_OPEN: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      lock_reg == SCL_ARMED && cmd_in.wr && cmd_in.sel == `SCL_SEL_OFFSET
      |=> offset_out == $past(cmd_in.data))
      else $error("write lost before power cycle");
   AST_NOT_ANALOG_ZERO: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      accept && cmd_in.rd && cmd_in.sel == `SCL_SEL_FIELD && fmt_reg != `SCL_FMT_ANALOG
      |=> rd_valid_out && rd_data_out == 16'h0000)
      else $error("field nonzero outside analog format");
   AST_FIELD_REVERSED: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      accept && cmd_in.rd && cmd_in.sel == `SCL_SEL_FIELD && fmt_reg == `SCL_FMT_ANALOG
      |=> rd_data_out[13] == $past(field_in[0]) && rd_data_out[0] == $past(field_in[13]))
      else $error("field readout not mirrored");
   AST_LOCK_NEEDS_CYCLE: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      lock_reg == SCL_ARMED |=> lock_reg == SCL_ARMED)
      else $error("lock took effect without power cycle");
   AST_REWRITE: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      accept && cmd_in.wr && cmd_in.sel == `SCL_SEL_GP |=> gp_out == $past(cmd_in.data))
      else $error("repeat write refused");
   // a stored lock seen in the boot cycle must freeze at once
   AST_BOOT_FREEZES: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      lock_reg == SCL_OPEN && boot_reg && nv_freeze_in
      |=> lock_reg == SCL_FROZEN && frozen_out)
      else $error("stored lock ignored at boot");
   AST_GP_FROZEN: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      lock_reg == SCL_FROZEN |=> $stable(gp_out))
      else $error("store changed while frozen");
   AST_FROZEN_STAYS: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      lock_reg == SCL_FROZEN |=> lock_reg == SCL_FROZEN)
      else $error("frozen state left");
   // a lock write in an open part arms and persists the bit
   AST_FREEZE_ARMS: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      lock_reg == SCL_OPEN && !(boot_reg && nv_freeze_in) && cmd_in.wr
      && cmd_in.sel == `SCL_SEL_FREEZE && cmd_in.data[0]
      |=> freeze_store_out && lock_reg == SCL_ARMED)
      else $error("lock write not armed");
   COV_ARM: cover property (@(posedge clock_in) lock_reg == SCL_ARMED);
   COV_NOT_ANALOG_READ: cover property (@(posedge clock_in) rd_valid_out && fmt_out != 3'h0);
   COV_FROZEN: cover property (@(posedge clock_in) frozen_out);
   COV_FIELD_READ: cover property (@(posedge clock_in) rd_valid_out && rd_data_out != 16'h0000);
endmodule // scl_lock_readout

//--- scl_nv_model.sv
// non-volatile lock store: reset never clears it, so it survives a power cycle
module scl_nv_model (
   input wire logic clock_in,
   input wire logic store_in, // lock bit to persist
   output logic nv_out // stored lock bit, read at boot
);
   timeunit 1ns;
   timeprecision 1ps;
   initial nv_out = 1'b0; // a fresh part starts unlocked
   // one-way store: once set it stays set
   always @(posedge clock_in) begin
      if (store_in) begin
         nv_out <= 1'b1;
      end
   end
endmodule // scl_nv_model

//--- testbench.sv
`include "scl_regs.svh"
module testbench
   import scl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_in = 1'b0;
   logic rst_n_in = 1'b0; // held low from time zero
   scl_cmd_s cmd_in = '0;
   logic [13:0] field_in = 14'h0000;
   logic [13:0] fld = 14'h0000; // field value sent with the next command
   logic nv_freeze_in, rd_valid_out, freeze_store_out, frozen_out;
   logic [15:0] rd_data_out, offset_out, gp_out;
   logic [2:0] fmt_out;
   int err_total = 0;
   int comparisons = 0;
   always #4 clock_in = ~clock_in; // 125 MHz
   scl_nv_model scl_nv_model_inst (.clock_in(clock_in), .store_in(freeze_store_out),
      .nv_out(nv_freeze_in));
   scl_lock_readout scl_lock_readout_inst (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .cmd_in(cmd_in), .field_in(field_in), .nv_freeze_in(nv_freeze_in),
      .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
      .freeze_store_out(freeze_store_out), .frozen_out(frozen_out),
      .offset_out(offset_out), .fmt_out(fmt_out), .gp_out(gp_out));
   // compare and count; case equality so unknowns never match
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // power cycle: reset low for three edges
   task automatic power_cycle();
      rst_n_in <= 1'b0;
      repeat (3) @(posedge clock_in);
      rst_n_in <= 1'b1;
   endtask
   // one telegram for one cycle; sample at the following falling edge
   task automatic send(input logic w, input logic r, input logic [3:0] s,
      input logic [15:0] d);
      @(posedge clock_in);
      cmd_in <= '{wr: w, rd: r, sel: s, data: d};
      field_in <= fld;
      @(posedge clock_in);
      cmd_in <= '0;
      @(negedge clock_in);
   endtask
   // read; the answer strobe stands one cycle only, so it is looked at then
   task automatic rd(input logic [3:0] s, input logic v, input logic [15:0] exp);
      send(1'b0, 1'b1, s, 16'h0000);
      chk({15'h0000, rd_valid_out}, {15'h0000, v});
      if (v) begin
         chk(rd_data_out, exp);
      end
   endtask
   // verdict in one place
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // hang guard, far beyond the roughly 81 cycles the tests need
   initial begin
      #20000;
      err_total++;
      close_out();
   end
   initial begin
      power_cycle();
      @(negedge clock_in);
      chk({11'h000, frozen_out, freeze_store_out, fmt_out}, 16'h0000);
      chk(offset_out | gp_out, 16'h0000);
      // every non-analog format reads the field as zero, though the field value sent here is zero too
      for (int i = 1; i < 8; i++) begin
         send(1'b1, 1'b0, `SCL_SEL_FORMAT, 16'(i));
         chk({13'h0000, fmt_out}, 16'(i));
         rd(`SCL_SEL_FIELD, 1'b1, 16'h0000);
      end
      send(1'b1, 1'b0, `SCL_SEL_FORMAT, 16'h0000);
      send(1'b1, 1'b0, `SCL_SEL_OFFSET, 16'h1234);
      chk(offset_out, 16'h1234);
      fld = 14'h0001;
      rd(`SCL_SEL_FIELD, 1'b1, 16'h2000);
      fld = 14'h2C05;
      rd(`SCL_SEL_FIELD, 1'b1, 16'h280D);
      send(1'b1, 1'b0, `SCL_SEL_OFFSET, 16'hABCD);
      chk(offset_out, 16'hABCD);
      send(1'b1, 1'b0, `SCL_SEL_GP, 16'h5A5A);
      chk(gp_out, 16'h5A5A);
      rd(`SCL_SEL_GP, 1'b1, 16'h5A5A);
      rd(4'hF, 1'b1, 16'h0000);
      // recalibration starts over from a fresh initial offset
      send(1'b1, 1'b0, `SCL_SEL_OFFSET, 16'h1234);
      rd(`SCL_SEL_OFFSET, 1'b1, 16'h1234);
      // lock write, then more writes; it arms only until the next power cycle
      send(1'b1, 1'b0, `SCL_SEL_FREEZE, 16'h0001);
      chk({14'h0000, freeze_store_out, frozen_out}, 16'h0002);
      rd(`SCL_SEL_FREEZE, 1'b1, 16'h0001);
      send(1'b1, 1'b0, `SCL_SEL_OFFSET, 16'h0F0F);
      chk(offset_out, 16'h0F0F);
      send(1'b1, 1'b0, `SCL_SEL_FREEZE, 16'h0000);
      chk({15'h0000, freeze_store_out}, 16'h0001);
      for (int p = 0; p < 2; p++) begin
         power_cycle();
         repeat (2) @(posedge clock_in);
         @(negedge clock_in);
         chk({15'h0000, frozen_out}, 16'h0001);
         send(1'b1, 1'b0, `SCL_SEL_OFFSET, 16'h7777);
         chk(offset_out, 16'h0000);
         rd(`SCL_SEL_FIELD, 1'b0, 16'h0000);
         send(1'b1, 1'b0, `SCL_SEL_FREEZE, 16'h0000);
         chk({15'h0000, frozen_out}, 16'h0001);
      end
      close_out();
   end
endmodule // testbench
